// File: src/cbf_pkg.sv
// shared constants, types and decode for the branch and file-op core
package cbf_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int PC_W = 11;
	localparam int INSTR_W = 12;
	localparam int FILE_DEPTH = 32;
	localparam int CLK_PERIOD_NS = 20;

	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_PC = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_WORK = 4'h3;
	localparam logic [3:0] REG_FSEL = 4'h4;
	localparam logic [3:0] REG_FDATA = 4'h5;
	localparam logic [3:0] REG_TOS = 4'h6;
	localparam logic [3:0] REG_CFG = 4'h7;

	localparam int STAT_PAGE_HI = 6;
	localparam int STAT_PAGE_LO = 5;
	localparam int STAT_TIMEOUT = 4;
	localparam int STAT_PWRDOWN = 3;
	localparam int STAT_ZERO = 2;
	localparam int CFG_PRESC_SEL = 0;
	localparam int CFG_BUSY = 1;

	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [10:0] PC_RST = 11'h000;
	localparam logic [10:0] PC_STEP = 11'h001;
	localparam logic [10:0] PC_SKIP = 11'h002;

	localparam logic [11:0] MASK_CALL = 12'hF00;
	localparam logic [11:0] CODE_CALL = 12'h900;
	localparam logic [11:0] MASK_BRANCH = 12'hE00;
	localparam logic [11:0] CODE_BRANCH = 12'hA00;
	localparam logic [11:0] MASK_WDCLR = 12'hFFF;
	localparam logic [11:0] CODE_WDCLR = 12'h004;
	localparam logic [11:0] MASK_ZERO = 12'hFE0;
	localparam logic [11:0] CODE_ZERO = 12'h060;
	localparam logic [11:0] MASK_FILEOP = 12'hFC0;
	localparam logic [11:0] CODE_INV = 12'h240;
	localparam logic [11:0] CODE_DEC = 12'h0C0;
	localparam logic [11:0] CODE_DECSKIP = 12'h2C0;

	typedef enum logic [7:0] {
		OP_NONE = 8'h01,
		OP_CALL = 8'h02,
		OP_BRANCH = 8'h04,
		OP_WDCLR = 8'h08,
		OP_ZERO = 8'h10,
		OP_INV = 8'h20,
		OP_DEC = 8'h40,
		OP_DECSKIP = 8'h80
	} cbf_op_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_EXEC = 3'h2,
		ST_FLUSH = 3'h4
	} cbf_state_e;

	typedef struct packed {
		cbf_op_e op;
		logic [4:0] fileIdx;
		logic dest;
		logic [8:0] lit;
	} cbf_instr_s;

	typedef struct packed {
		logic counterClear;
		logic prescalerClear;
	} cbf_watchdog_s;

	function automatic cbf_instr_s decode(input logic [11:0] w);
		cbf_instr_s d;
		d.fileIdx = w[4:0];
		d.dest = w[5];
		d.lit = w[8:0];
		if ((w & MASK_CALL) == CODE_CALL) begin
			d.op = OP_CALL;
		end else if ((w & MASK_BRANCH) == CODE_BRANCH) begin
			d.op = OP_BRANCH;
		end else if ((w & MASK_WDCLR) == CODE_WDCLR) begin
			d.op = OP_WDCLR;
		end else if ((w & MASK_ZERO) == CODE_ZERO) begin
			d.op = OP_ZERO;
		end else if ((w & MASK_FILEOP) == CODE_INV) begin
			d.op = OP_INV;
		end else if ((w & MASK_FILEOP) == CODE_DEC) begin
			d.op = OP_DEC;
		end else if ((w & MASK_FILEOP) == CODE_DECSKIP) begin
			d.op = OP_DECSKIP;
		end else begin
			d.op = OP_NONE;
		end
		return d;
	endfunction
endpackage

// File: src/cbf_alu.sv
// single-operand file arithmetic with zero detect
`timescale 1ns/1ps
`default_nettype none
module cbf_alu (
	input wire cbf_pkg::cbf_op_e op,
	input wire logic [7:0] operand,
	output logic [7:0] result,
	output logic zero
);
	always_comb begin
		case (op)
			cbf_pkg::OP_ZERO: result = 8'h00;
			cbf_pkg::OP_INV: result = ~operand;
			cbf_pkg::OP_DEC: result = operand - 8'h01;
			cbf_pkg::OP_DECSKIP: result = operand - 8'h01;
			default: result = operand;
		endcase
		zero = (result == 8'h00);
	end
endmodule
`default_nettype wire

// File: src/cbf_core.sv
// branch, call, watchdog clear and file-op execution core
`timescale 1ns/1ps
`default_nettype none
module cbf_core (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] addr,
	input wire logic [15:0] wrData,
	input wire logic wrEn,
	input wire logic rdEn,
	output logic [15:0] rdData_r,
	output logic [10:0] pc_r,
	output logic [10:0] tos_r,
	output logic stackPush_r,
	output cbf_pkg::cbf_watchdog_s watchdog_r,
	output logic flush_r,
	output logic busy_r,
	output logic doneP_r
);
	cbf_pkg::cbf_state_e state_r, state_nxt;
	cbf_pkg::cbf_instr_s instr_r;
	logic [11:0] cmdWord_r;
	logic [7:0] status_r;
	logic [7:0] work_r;
	logic [4:0] fsel_r;
	logic prescSel_r;
	logic [7:0] fileMem [cbf_pkg::FILE_DEPTH];
	logic [7:0] aluRes;
	logic aluZero;
	logic exec, cmdWrite, twoCycle;
	logic isCall, isBranch, isWdclr, isZero, isInv, isDec, isSkip;
	logic fileOp;

	assign exec = (state_r == cbf_pkg::ST_EXEC);
	// commands while busy are dropped, software polls busy
	assign cmdWrite = wrEn && (addr == cbf_pkg::REG_CMD)
		&& (state_r == cbf_pkg::ST_IDLE);
	assign isCall = exec && (instr_r.op == cbf_pkg::OP_CALL);
	assign isBranch = exec && (instr_r.op == cbf_pkg::OP_BRANCH);
	assign isWdclr = exec && (instr_r.op == cbf_pkg::OP_WDCLR);
	assign isZero = exec && (instr_r.op == cbf_pkg::OP_ZERO);
	assign isInv = exec && (instr_r.op == cbf_pkg::OP_INV);
	assign isDec = exec && (instr_r.op == cbf_pkg::OP_DEC);
	assign isSkip = exec && (instr_r.op == cbf_pkg::OP_DECSKIP);
	assign fileOp = isInv || isDec || isSkip;
	assign twoCycle = isCall || isBranch || (isSkip && aluZero);

	cbf_alu u_alu (
		.op(instr_r.op),
		.operand(fileMem[instr_r.fileIdx]),
		.result(aluRes),
		.zero(aluZero)
	);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			cbf_pkg::ST_IDLE: begin
				if (cmdWrite) begin
					state_nxt = cbf_pkg::ST_EXEC;
				end
			end
			cbf_pkg::ST_EXEC: begin
				if (twoCycle) begin
					state_nxt = cbf_pkg::ST_FLUSH;
				end else begin
					state_nxt = cbf_pkg::ST_IDLE;
				end
			end
			cbf_pkg::ST_FLUSH: state_nxt = cbf_pkg::ST_IDLE;
			default: state_nxt = cbf_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= cbf_pkg::ST_IDLE;
			busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			busy_r <= (state_nxt != cbf_pkg::ST_IDLE);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmdWord_r <= 12'h000;
			instr_r <= '{op: cbf_pkg::OP_NONE, default: '0};
		end else if (cmdWrite) begin
			cmdWord_r <= wrData[11:0];
			instr_r <= cbf_pkg::decode(wrData[11:0]);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			doneP_r <= 1'b0;
			flush_r <= 1'b0;
		end else begin
			doneP_r <= (exec && !twoCycle)
				|| (state_r == cbf_pkg::ST_FLUSH);
			flush_r <= twoCycle;
		end
	end

	// counter holds the address of the instruction under execution
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_r <= cbf_pkg::PC_RST;
		end else if (isCall) begin
			pc_r <= {status_r[cbf_pkg::STAT_PAGE_HI:cbf_pkg::STAT_PAGE_LO],
				1'b0, instr_r.lit[7:0]};
		end else if (isBranch) begin
			pc_r <= {status_r[cbf_pkg::STAT_PAGE_HI:cbf_pkg::STAT_PAGE_LO],
				instr_r.lit};
		end else if (isSkip && aluZero) begin
			pc_r <= pc_r + cbf_pkg::PC_SKIP;
		end else if (exec) begin
			pc_r <= pc_r + cbf_pkg::PC_STEP;
		end else if (wrEn && (addr == cbf_pkg::REG_PC)) begin
			pc_r <= wrData[10:0];
		end
	end

	// only the top entry lives here; deeper levels sit outside
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tos_r <= 11'h000;
			stackPush_r <= 1'b0;
		end else begin
			stackPush_r <= isCall;
			if (isCall) begin
				tos_r <= pc_r + cbf_pkg::PC_STEP;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_r <= '0;
		end else begin
			watchdog_r.counterClear <= isWdclr;
			watchdog_r.prescalerClear <= isWdclr && prescSel_r;
		end
	end

	// call, branch and skip leave every flag alone
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_r <= cbf_pkg::STATUS_RST;
		end else if (isWdclr) begin
			status_r[cbf_pkg::STAT_TIMEOUT] <= 1'b1;
			status_r[cbf_pkg::STAT_PWRDOWN] <= 1'b1;
		end else if (isZero) begin
			status_r[cbf_pkg::STAT_ZERO] <= 1'b1;
		end else if (isInv || isDec) begin
			status_r[cbf_pkg::STAT_ZERO] <= aluZero;
		end else if (wrEn && (addr == cbf_pkg::REG_STATUS)) begin
			status_r <= wrData[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			work_r <= 8'h00;
		end else if (fileOp && !instr_r.dest) begin
			work_r <= aluRes;
		end else if (wrEn && (addr == cbf_pkg::REG_WORK)) begin
			work_r <= wrData[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fsel_r <= 5'h00;
			prescSel_r <= 1'b0;
		end else if (wrEn) begin
			if (addr == cbf_pkg::REG_FSEL) begin
				fsel_r <= wrData[4:0];
			end
			if (addr == cbf_pkg::REG_CFG) begin
				prescSel_r <= wrData[cbf_pkg::CFG_PRESC_SEL];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < cbf_pkg::FILE_DEPTH; i++) begin
				fileMem[i] <= 8'h00;
			end
		end else if (isZero) begin
			fileMem[instr_r.fileIdx] <= 8'h00;
		end else if (fileOp && instr_r.dest) begin
			fileMem[instr_r.fileIdx] <= aluRes;
		end else if (wrEn && (addr == cbf_pkg::REG_FDATA)) begin
			fileMem[fsel_r] <= wrData[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_r <= 16'h0000;
		end else if (rdEn) begin
			case (addr)
				cbf_pkg::REG_CMD: rdData_r <= {4'h0, cmdWord_r};
				cbf_pkg::REG_PC: rdData_r <= {5'h00, pc_r};
				cbf_pkg::REG_STATUS: rdData_r <= {8'h00, status_r};
				cbf_pkg::REG_WORK: rdData_r <= {8'h00, work_r};
				cbf_pkg::REG_FSEL: rdData_r <= {11'h000, fsel_r};
				cbf_pkg::REG_FDATA: rdData_r <= {8'h00, fileMem[fsel_r]};
				cbf_pkg::REG_TOS: rdData_r <= {5'h00, tos_r};
				cbf_pkg::REG_CFG: rdData_r <= {14'h0000, busy_r, prescSel_r};
				default: rdData_r <= 16'h0000;
			endcase
		end else begin
			rdData_r <= 16'h0000;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_call_push;
		isCall |=> stackPush_r && (tos_r == $past(pc_r) + cbf_pkg::PC_STEP);
	endproperty
	a_call_push: assert property (p_call_push)
		else $error("call did not push return address");

	property p_call_target;
		isCall |=> pc_r == {$past(status_r[6:5]), 1'b0, $past(instr_r.lit[7:0])};
	endproperty
	a_call_target: assert property (p_call_target)
		else $error("call target wrong");

	property p_two_cycle;
		(isCall || isBranch) |=> (state_r == cbf_pkg::ST_FLUSH) && busy_r
			##1 (state_r == cbf_pkg::ST_IDLE) && doneP_r;
	endproperty
	a_two_cycle: assert property (p_two_cycle)
		else $error("call or branch not two cycles");

	property p_branch_target;
		isBranch |=> pc_r == {$past(status_r[6:5]), $past(instr_r.lit)};
	endproperty
	a_branch_target: assert property (p_branch_target)
		else $error("branch target wrong");

	property p_flags_kept;
		(isCall || isBranch || isSkip)
			&& !(wrEn && (addr == cbf_pkg::REG_STATUS)) |=> $stable(status_r);
	endproperty
	a_flags_kept: assert property (p_flags_kept)
		else $error("flags changed by flag-neutral op");

	property p_branch_nopush;
		isBranch |=> !stackPush_r ##1 !stackPush_r;
	endproperty
	a_branch_nopush: assert property (p_branch_nopush)
		else $error("branch pushed the stack");

	property p_wdclr;
		isWdclr |=> watchdog_r.counterClear
			&& (watchdog_r.prescalerClear == $past(prescSel_r))
			&& status_r[4] && status_r[3];
	endproperty
	a_wdclr: assert property (p_wdclr)
		else $error("watchdog clear effects wrong");

	property p_zero_op;
		isZero |=> status_r[2] && (fileMem[$past(instr_r.fileIdx)] == 8'h00);
	endproperty
	a_zero_op: assert property (p_zero_op)
		else $error("register zero op wrong");

	property p_to_work;
		fileOp && !instr_r.dest |=> work_r == $past(aluRes);
	endproperty
	a_to_work: assert property (p_to_work)
		else $error("result not in work register");

	property p_zero_flag;
		(isInv || isDec) |=> status_r[2] == ($past(aluRes) == 8'h00);
	endproperty
	a_zero_flag: assert property (p_zero_flag)
		else $error("zero flag mismatch");

	property p_skip;
		isSkip && aluZero |=> flush_r && (pc_r == $past(pc_r) + 11'h002)
			##1 !flush_r && doneP_r;
	endproperty
	a_skip: assert property (p_skip)
		else $error("skip did not discard prefetch");

	property p_single;
		exec && !twoCycle |=> (state_r == cbf_pkg::ST_IDLE) && doneP_r
			&& !flush_r;
	endproperty
	a_single: assert property (p_single)
		else $error("single-cycle op took longer");

	property p_to_file;
		fileOp && instr_r.dest
			|=> fileMem[$past(instr_r.fileIdx)] == $past(aluRes);
	endproperty
	a_to_file: assert property (p_to_file)
		else $error("result not in file register");

	// judged against the operand, so a broken alu cannot hide
	property p_inv_value;
		isInv && !instr_r.dest
			|=> work_r == ~$past(fileMem[instr_r.fileIdx]);
	endproperty
	a_inv_value: assert property (p_inv_value)
		else $error("invert result wrong");

	property p_dec_value;
		(isDec || isSkip) && !instr_r.dest
			|=> work_r == $past(fileMem[instr_r.fileIdx]) - 8'h01;
	endproperty
	a_dec_value: assert property (p_dec_value)
		else $error("decrement result wrong");

	property p_noskip;
		isSkip && !aluZero |=> !flush_r
			&& (pc_r == $past(pc_r) + cbf_pkg::PC_STEP);
	endproperty
	a_noskip: assert property (p_noskip)
		else $error("skip taken on non-zero result");

	property p_push_only_call;
		!isCall |=> !stackPush_r;
	endproperty
	a_push_only_call: assert property (p_push_only_call)
		else $error("stack pushed without a call");

	property p_wd_quiet;
		!isWdclr
			|=> !watchdog_r.counterClear && !watchdog_r.prescalerClear;
	endproperty
	a_wd_quiet: assert property (p_wd_quiet)
		else $error("watchdog cleared without request");

	property p_accept;
		cmdWrite |=> exec && busy_r;
	endproperty
	a_accept: assert property (p_accept)
		else $error("command not taken");

	c_call: cover property (isCall ##2 doneP_r);
	c_skip_taken: cover property (isSkip && aluZero);
	c_skip_not: cover property (isSkip && !aluZero);
	c_wdclr_presc: cover property (isWdclr && prescSel_r);
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench for the branch and file-op core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [3:0] CM = cbf_pkg::REG_CMD;
	localparam logic [3:0] PC = cbf_pkg::REG_PC;
	localparam logic [3:0] ST = cbf_pkg::REG_STATUS;
	localparam logic [3:0] WK = cbf_pkg::REG_WORK;
	localparam logic [3:0] FS = cbf_pkg::REG_FSEL;
	localparam logic [3:0] FD = cbf_pkg::REG_FDATA;
	localparam logic [3:0] TS = cbf_pkg::REG_TOS;
	localparam logic [3:0] CF = cbf_pkg::REG_CFG;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wrData = 16'h0000;
	logic wrEn = 1'b0;
	logic rdEn = 1'b0;
	logic [15:0] rdData_r;
	logic [10:0] pc_r;
	logic [10:0] tos_r;
	logic [10:0] pc0;
	logic stackPush_r;
	logic flush_r;
	logic busy_r;
	logic doneP_r;
	cbf_pkg::cbf_watchdog_s watchdog_r;
	logic sawPush;
	logic sawFlush;
	logic sawCnt;
	logic sawPre;
	int err_count = 0;
	int cmp_count = 0;

	cbf_core i_cbf_core (.clk(clk), .rst_n(rst_n), .addr(addr),
		.wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData_r(rdData_r),
		.pc_r(pc_r), .tos_r(tos_r), .stackPush_r(stackPush_r),
		.watchdog_r(watchdog_r), .flush_r(flush_r), .busy_r(busy_r),
		.doneP_r(doneP_r));

	initial begin
		forever #(cbf_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
	end

	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] s,
		input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wrEn <= 1'b1;
		addr <= a;
		wrData <= d;
		@(posedge clk);
		wrEn <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rc(input string n, input logic [3:0] a,
		input logic [15:0] e);
		@(posedge clk);
		rdEn <= 1'b1;
		addr <= a;
		@(posedge clk);
		rdEn <= 1'b0;
		#1;
		chk(n, rdData_r, e);
	endtask

	task automatic setf(input logic [4:0] i, input logic [7:0] v);
		wr(FS, {11'h000, i});
		wr(FD, {8'h00, v});
	endtask

	// pulses last one cycle, so they are gathered while waiting
	task automatic run(input logic [11:0] w, input int cyc);
		int n;
		n = 0;
		sawPush = 1'b0;
		sawFlush = 1'b0;
		sawCnt = 1'b0;
		sawPre = 1'b0;
		wr(CM, {4'h0, w});
		#1;
		pc0 = pc_r;
		chk("busy", {15'h0000, busy_r}, 16'h0001);
		do begin
			@(posedge clk);
			#1;
			n++;
			sawPush |= (stackPush_r === 1'b1);
			sawFlush |= (flush_r === 1'b1);
			sawCnt |= (watchdog_r.counterClear === 1'b1);
			sawPre |= (watchdog_r.prescalerClear === 1'b1);
		end while (doneP_r !== 1'b1 && n < 9);
		chk("cycles", 16'(n), 16'(cyc));
		if (doneP_r !== 1'b1) begin
			complete_run();
		end
		chk("idle", {15'h0000, busy_r}, 16'h0000);
	endtask

	task automatic t_reset();
		rc("reset status", ST, 16'h0018);
		rc("reset pc", PC, 16'h0000);
		rc("unmapped", 4'h8, 16'h0000);
		$display("reset test done");
	endtask

	task automatic t_call();
		wr(ST, 16'h0078);
		wr(PC, 16'h0123);
		run(12'h9AB, 2);
		chk("call pc", {5'h00, pc_r}, 16'h06AB);
		chk("call tos", {5'h00, tos_r}, 16'h0124);
		chk("call push", {15'h0000, sawPush}, 16'h0001);
		rc("call status", ST, 16'h0078);
		rc("call tos reg", TS, 16'h0124);
		$display("call test done");
	endtask

	task automatic t_branch();
		wr(ST, 16'h003C);
		run(12'hBFF, 2);
		chk("branch pc", {5'h00, pc_r}, 16'h03FF);
		chk("branch push", {15'h0000, sawPush}, 16'h0000);
		rc("branch status", ST, 16'h003C);
		rc("branch tos", TS, 16'h0124);
		$display("branch test done");
	endtask

	task automatic t_wdog();
		wr(ST, 16'h0000);
		wr(CF, 16'h0001);
		rc("cfg assign", CF, 16'h0001);
		run(12'h004, 1);
		chk("wd counter", {15'h0000, sawCnt}, 16'h0001);
		chk("wd prescaler", {15'h0000, sawPre}, 16'h0001);
		chk("wd pc", {5'h00, pc_r}, {5'h00, pc0 + 11'h001});
		rc("wd status", ST, 16'h0018);
		wr(CF, 16'h0000);
		run(12'h004, 1);
		chk("wd counter2", {15'h0000, sawCnt}, 16'h0001);
		chk("wd prescaler2", {15'h0000, sawPre}, 16'h0000);
		// unknown word runs as a plain step with no side effects
		run(12'h000, 1);
		chk("nop pc", {5'h00, pc_r}, {5'h00, pc0 + 11'h001});
		chk("nop counter", {15'h0000, sawCnt}, 16'h0000);
		chk("nop flush", {15'h0000, sawFlush}, 16'h0000);
		$display("watchdog test done");
	endtask

	task automatic t_zero();
		setf(5'h1F, 8'h55);
		wr(ST, 16'h0018);
		run(12'h07F, 1);
		rc("zero file", FD, 16'h0000);
		rc("zero status", ST, 16'h001C);
		$display("zero test done");
	endtask

	task automatic t_inv();
		setf(5'h03, 8'hFF);
		wr(WK, 16'h005A);
		wr(ST, 16'h0018);
		run(12'h243, 1);
		rc("inv w", WK, 16'h0000);
		rc("inv file kept", FD, 16'h00FF);
		rc("inv z set", ST, 16'h001C);
		setf(5'h03, 8'h0F);
		run(12'h263, 1);
		rc("inv file", FD, 16'h00F0);
		rc("inv z clear", ST, 16'h0018);
		$display("invert test done");
	endtask

	task automatic t_dec();
		setf(5'h05, 8'h01);
		wr(WK, 16'h00AA);
		run(12'h0C5, 1);
		rc("dec w", WK, 16'h0000);
		rc("dec z set", ST, 16'h001C);
		setf(5'h05, 8'h00);
		run(12'h0E5, 1);
		rc("dec wrap", FD, 16'h00FF);
		rc("dec z clear", ST, 16'h0018);
		$display("decrement test done");
	endtask

	// zero result must not touch the zero flag here
	task automatic t_skip();
		wr(ST, 16'h0018);
		setf(5'h07, 8'h02);
		run(12'h2E7, 1);
		chk("noskip pc", {5'h00, pc_r}, {5'h00, pc0 + 11'h001});
		chk("noskip flush", {15'h0000, sawFlush}, 16'h0000);
		rc("noskip file", FD, 16'h0001);
		run(12'h2E7, 2);
		chk("skip pc", {5'h00, pc_r}, {5'h00, pc0 + 11'h002});
		chk("skip flush", {15'h0000, sawFlush}, 16'h0001);
		rc("skip file", FD, 16'h0000);
		rc("skip status", ST, 16'h0018);
		setf(5'h07, 8'h01);
		wr(WK, 16'h0033);
		run(12'h2C7, 2);
		rc("skip w", WK, 16'h0000);
		rc("skip file kept", FD, 16'h0001);
		$display("skip test done");
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_call();
		t_branch();
		t_wdog();
		t_zero();
		t_inv();
		t_dec();
		t_skip();
		complete_run();
	end
endmodule
`default_nettype wire
